// file: design/fault_status_pkg.sv
// constants shared by the fault status bank: command codes, bit positions, reset values
package fault_status_pkg;
  // command codes seen on the command port
  localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CODE_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CODE_OUTPUT_VOLTAGE_SUMMARY_STATUS = 8'h7A;
  localparam logic [7:0] CODE_OUTPUT_CURRENT_SUMMARY_STATUS = 8'h7B;
  localparam logic [7:0] CODE_THERMAL_STATUS = 8'h7D;
  localparam logic [7:0] CODE_CML_STATUS = 8'h7E;
  // fault_summary_word bit positions
  localparam int SUM_OUTPUT_VOLTAGE_SUMMARY = 15;
  localparam int SUM_OUTPUT_CURRENT_SUMMARY = 14;
  localparam int SUM_MAKER = 12;
  localparam int SUM_POWER_LOST = 11;
  localparam int SUM_MARGIN = 8;
  localparam int SUM_SEQ_OFF = 6;
  localparam int SUM_OV = 5;
  localparam int SUM_OC = 4;
  localparam int SUM_TEMP = 2;
  localparam int SUM_CML = 1;
  localparam logic [15:0] SUM_USED = 16'hD976;
  // byte register bit positions
  localparam int VB_OV_FAULT = 7;
  localparam int VB_OV_WARN = 6;
  localparam int VB_UV_WARN = 5;
  localparam int VB_UV_FAULT = 4;
  localparam int VB_TON = 2;
  localparam int IB_OC_FAULT = 7;
  localparam int IB_OC_WARN = 5;
  localparam int TB_OVERHEAT_FAULT_FLAG = 7;
  localparam int TB_OVERHEAT_WARNING_FLAG = 6;
  localparam int CB_BAD_CMD = 7;
  localparam int CB_BAD_DATA = 6;
  localparam int CB_SECONDARY = 2;
  localparam int CB_MAIN = 1;
  localparam int CB_LOG_FULL = 0;
  // index of each latched flag inside the sticky flag vector
  localparam int NUM_LATCHED = 14;
  localparam int L_OV_FAULT = 13;
  localparam int L_OV_WARN = 12;
  localparam int L_UV_WARN = 11;
  localparam int L_UV_FAULT = 10;
  localparam int L_TON = 9;
  localparam int L_OC_FAULT = 8;
  localparam int L_OC_WARN = 7;
  localparam int L_OVERHEAT_FAULT_FLAG = 6;
  localparam int L_OVERHEAT_WARNING_FLAG = 5;
  localparam int L_BAD_CMD = 4;
  localparam int L_BAD_DATA = 3;
  localparam int L_SECONDARY = 2;
  localparam int L_MAIN = 1;
  localparam int L_MARGIN = 0;
  // flags that may raise the alert; flash corruption flags may not
  localparam logic [13:0] ALERT_MASK = 14'h3FF9;
  // reset values
  localparam logic ALERT_PENDING_RESET = 1'b0;
  localparam logic LOG_FULL_RESET = 1'b0;
endpackage : fault_status_pkg

// file: design/flag_if.sv
// set, clear and state of a vector of sticky flags
interface flag_if #(parameter int WIDTH = 14) (input wire logic clock, input wire logic reset_n);
  logic [WIDTH-1:0] set;
  logic clear;
  logic [WIDTH-1:0] q;
  modport owner (input clock, input reset_n, input set, input clear, output q);
  modport user (output set, output clear, input q);
endinterface : flag_if

// file: design/sticky_flags.sv
// vector of sticky flags where a set in the clear cycle wins
module sticky_flags (
  flag_if.owner f
);
  // a clear reloads the flags from the present set terms, so a persisting condition
  // or an event in the clear cycle is never lost
  always_ff @(posedge f.clock or negedge f.reset_n)
  begin
    if (!f.reset_n)
    begin
      f.q <= '0;
    end
    else if (f.clear)
    begin
      f.q <= f.set;
    end
    else
    begin
      f.q <= f.q | f.set;
    end
  end
endmodule : sticky_flags

// file: design/pmbus_fault_status_bank.sv
// fault and warning status bank with summary word, byte registers and alert
// Functional notes
// - summary bit 15 set by any voltage fault, warning or turn-on timeout
// - summary bit 14 set by any overcurrent fault or warning
// - summary bit 12 set while any maker status byte bit is set
// - summary bit 11 is OR of all per-rail power-lost flags
// - summary bit 8 set by a margining fault on any rail
// - summary bit 6 is OR of all per-rail sequenced-off flags
// - summary bits 5, 4: overvoltage, overcurrent fault only; bit 2: temperature fault or warning
// - summary bit 1 set by a recorded communication, memory or logic fault
// - all unassigned status bits read zero
// - sequenced-off and power-lost summary bits never raise the alert themselves
// - voltage flags latch; re-set if condition persists, timeout only on new event
// - voltage byte: bits 7,6,5,4 over/under fault/warning, bit 2 timeout
// - current byte: latched fault bit 7, warning bit 5, re-set while persisting
// - thermal byte: latched fault bit 7, warning bit 6, re-set while persisting
// - bad command code latches bit 7 of the comm/memory/logic byte
// - bad data with a command latches bit 6 of that byte
// - secondary flash corrupt latches bit 2, main flash corrupt latches bit 1
// - comm flags re-set only on new event; bit 0 tracks log fullness live
// - with wraparound enabled log-full clears when the log is overwritten
// - flash corruption flags never raise the alert
// - alert reaches the host only while alerting is enabled in mode config
module pmbus_fault_status_bank #(
  parameter int CHANNELS = 16,
  parameter int RAILS = 12,
  parameter int SENSORS = 5
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output logic [15:0] read_data,
  output logic read_valid,
  output logic read_known,
  input wire logic [CHANNELS-1:0] ov_fault_cond,
  input wire logic [CHANNELS-1:0] ov_warn_cond,
  input wire logic [CHANNELS-1:0] uv_warn_cond,
  input wire logic [CHANNELS-1:0] uv_fault_cond,
  input wire logic [RAILS-1:0] turn_on_timeout_event,
  input wire logic [CHANNELS-1:0] oc_fault_cond,
  input wire logic [CHANNELS-1:0] oc_warn_cond,
  input wire logic [SENSORS-1:0] overheat_fault_flag_cond,
  input wire logic [SENSORS-1:0] overheat_warning_flag_cond,
  input wire logic [RAILS-1:0] margin_fault_event,
  input wire logic [RAILS-1:0] power_lost,
  input wire logic [RAILS-1:0] sequenced_off,
  input wire logic [7:0] maker_status_byte,
  input wire logic bad_command_event,
  input wire logic bad_data_event,
  input wire logic secondary_array_corrupt_event,
  input wire logic main_array_corrupt_event,
  input wire logic log_is_full,
  input wire logic log_overwrite,
  input wire logic log_wraparound_enable,
  input wire logic alert_enable,
  output logic alert_n
);

  //////////////////////////////////////////////////////////////////////////////
  // sticky flags

  logic clear_faults;
  logic [fault_status_pkg::NUM_LATCHED-1:0] flag_set;
  logic [fault_status_pkg::NUM_LATCHED-1:0] flag_q;
  logic log_full_flag;
  logic alert_pending;
  logic new_alert;
  logic [15:0] summary;
  logic [7:0] output_voltage_summary_byte;
  logic [7:0] output_current_summary_byte;
  logic [7:0] thermal_byte;
  logic [7:0] cml_byte;
  logic [15:0] next_read_data;
  logic next_known;

  flag_if #(.WIDTH(fault_status_pkg::NUM_LATCHED)) flags (.clock(clock), .reset_n(reset_n));

  sticky_flags u_flags (
    .f(flags)
  );

  // clear-faults is a send-byte command decoded on the same port as reads
  assign clear_faults = cmd_valid && (cmd_code == fault_status_pkg::CODE_CLEAR_FAULTS);
  assign flags.clear = clear_faults;
  assign flags.set = flag_set;
  assign flag_q = flags.q;

  // set terms: conditions are levels so a cleared flag re-sets while they persist,
  // timeout and comm/flash terms are pulses so they re-set only on a new event
  always_comb
  begin
    flag_set = '0;
    flag_set[fault_status_pkg::L_OV_FAULT] = |ov_fault_cond;
    flag_set[fault_status_pkg::L_OV_WARN] = |ov_warn_cond;
    flag_set[fault_status_pkg::L_UV_WARN] = |uv_warn_cond;
    flag_set[fault_status_pkg::L_UV_FAULT] = |uv_fault_cond;
    flag_set[fault_status_pkg::L_TON] = |turn_on_timeout_event;
    flag_set[fault_status_pkg::L_OC_FAULT] = |oc_fault_cond;
    flag_set[fault_status_pkg::L_OC_WARN] = |oc_warn_cond;
    flag_set[fault_status_pkg::L_OVERHEAT_FAULT_FLAG] = |overheat_fault_flag_cond;
    flag_set[fault_status_pkg::L_OVERHEAT_WARNING_FLAG] = |overheat_warning_flag_cond;
    flag_set[fault_status_pkg::L_BAD_CMD] = bad_command_event;
    flag_set[fault_status_pkg::L_BAD_DATA] = bad_data_event;
    flag_set[fault_status_pkg::L_SECONDARY] = secondary_array_corrupt_event;
    flag_set[fault_status_pkg::L_MAIN] = main_array_corrupt_event;
    flag_set[fault_status_pkg::L_MARGIN] = |margin_fault_event;
  end

  // log-full follows the log live; an overwrite in wraparound mode drops it at once
  // because the log controller frees two entries before writing over them
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      log_full_flag <= fault_status_pkg::LOG_FULL_RESET;
    end
    else
    begin
      log_full_flag <= log_is_full && !(log_wraparound_enable && log_overwrite);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register images, unassigned bits stay zero

  always_comb
  begin
    output_voltage_summary_byte = '0;
    output_voltage_summary_byte[fault_status_pkg::VB_OV_FAULT] = flag_q[fault_status_pkg::L_OV_FAULT];
    output_voltage_summary_byte[fault_status_pkg::VB_OV_WARN] = flag_q[fault_status_pkg::L_OV_WARN];
    output_voltage_summary_byte[fault_status_pkg::VB_UV_WARN] = flag_q[fault_status_pkg::L_UV_WARN];
    output_voltage_summary_byte[fault_status_pkg::VB_UV_FAULT] = flag_q[fault_status_pkg::L_UV_FAULT];
    output_voltage_summary_byte[fault_status_pkg::VB_TON] = flag_q[fault_status_pkg::L_TON];
    output_current_summary_byte = '0;
    output_current_summary_byte[fault_status_pkg::IB_OC_FAULT] = flag_q[fault_status_pkg::L_OC_FAULT];
    output_current_summary_byte[fault_status_pkg::IB_OC_WARN] = flag_q[fault_status_pkg::L_OC_WARN];
    thermal_byte = '0;
    thermal_byte[fault_status_pkg::TB_OVERHEAT_FAULT_FLAG] = flag_q[fault_status_pkg::L_OVERHEAT_FAULT_FLAG];
    thermal_byte[fault_status_pkg::TB_OVERHEAT_WARNING_FLAG] = flag_q[fault_status_pkg::L_OVERHEAT_WARNING_FLAG];
    cml_byte = '0;
    cml_byte[fault_status_pkg::CB_BAD_CMD] = flag_q[fault_status_pkg::L_BAD_CMD];
    cml_byte[fault_status_pkg::CB_BAD_DATA] = flag_q[fault_status_pkg::L_BAD_DATA];
    cml_byte[fault_status_pkg::CB_SECONDARY] = flag_q[fault_status_pkg::L_SECONDARY];
    cml_byte[fault_status_pkg::CB_MAIN] = flag_q[fault_status_pkg::L_MAIN];
    cml_byte[fault_status_pkg::CB_LOG_FULL] = log_full_flag;
  end

  // summary word; power-lost and sequenced-off are live ORs, not latched
  always_comb
  begin
    summary = '0;
    summary[fault_status_pkg::SUM_OUTPUT_VOLTAGE_SUMMARY] = |output_voltage_summary_byte;
    summary[fault_status_pkg::SUM_OUTPUT_CURRENT_SUMMARY] = |output_current_summary_byte;
    summary[fault_status_pkg::SUM_MAKER] = |maker_status_byte;
    summary[fault_status_pkg::SUM_POWER_LOST] = |power_lost;
    summary[fault_status_pkg::SUM_MARGIN] = flag_q[fault_status_pkg::L_MARGIN];
    summary[fault_status_pkg::SUM_SEQ_OFF] = |sequenced_off;
    summary[fault_status_pkg::SUM_OV] = flag_q[fault_status_pkg::L_OV_FAULT];
    summary[fault_status_pkg::SUM_OC] = flag_q[fault_status_pkg::L_OC_FAULT];
    summary[fault_status_pkg::SUM_TEMP] = |thermal_byte;
    // log-full alone is a housekeeping state, not a recorded fault
    summary[fault_status_pkg::SUM_CML] = |cml_byte[7:1];
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  // decode of the command code into the read image
  always_comb
  begin
    next_known = 1'b1;
    next_read_data = '0;
    case (cmd_code)
      fault_status_pkg::CODE_SUMMARY_WORD: next_read_data = summary;
      fault_status_pkg::CODE_OUTPUT_VOLTAGE_SUMMARY_STATUS: next_read_data = {8'h00, output_voltage_summary_byte};
      fault_status_pkg::CODE_OUTPUT_CURRENT_SUMMARY_STATUS: next_read_data = {8'h00, output_current_summary_byte};
      fault_status_pkg::CODE_THERMAL_STATUS: next_read_data = {8'h00, thermal_byte};
      fault_status_pkg::CODE_CML_STATUS: next_read_data = {8'h00, cml_byte};
      default: next_known = 1'b0; // other codes belong to other blocks
    endcase
  end

  // answer one cycle after the command; data hold until the next read
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      read_data <= 16'h0000;
      read_valid <= 1'b0;
      read_known <= 1'b0;
    end
    else
    begin
      read_valid <= cmd_valid && !clear_faults;
      if (cmd_valid && !clear_faults)
      begin
        read_data <= next_read_data;
        read_known <= next_known;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // alert

  // a flag that newly sets (or sets again right across a clear) requests the alert;
  // the mask keeps flash corruption out, and power-lost and sequenced-off never enter
  assign new_alert = |(flag_set & fault_status_pkg::ALERT_MASK &
                       ~(flag_q & {fault_status_pkg::NUM_LATCHED{!clear_faults}}));

  // pending alert: a new request in the clear cycle wins over the clear
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alert_pending <= fault_status_pkg::ALERT_PENDING_RESET;
    end
    else if (new_alert)
    begin
      alert_pending <= 1'b1;
    end
    else if (clear_faults)
    begin
      alert_pending <= 1'b0;
    end
  end

  // enable gates the pin, not the pending state, so enabling later still alerts
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alert_n <= 1'b1;
    end
    else
    begin
      alert_n <= !(alert_pending && alert_enable);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence summary_read_s;
    cmd_valid && (cmd_code == fault_status_pkg::CODE_SUMMARY_WORD);
  endsequence

  sequence cml_read_s;
    cmd_valid && (cmd_code == fault_status_pkg::CODE_CML_STATUS);
  endsequence

  sequence alert_raise_s;
    new_alert && alert_enable ##1 alert_enable;
  endsequence

  output_voltage_summary_summary_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> read_data[15] == $past(|flag_q[13:9]))
    else $error("summary voltage bit wrong");

  output_current_summary_summary_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> read_data[14] == $past(flag_q[8] || flag_q[7]))
    else $error("summary current bit wrong");

  live_or_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> read_data[11] == $past(|power_lost) && read_data[6] == $past(|sequenced_off))
    else $error("summary live bits wrong");

  summary_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> (read_data & ~fault_status_pkg::SUM_USED) == 16'h0000)
    else $error("unused summary bit set");

  cml_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    cml_read_s |=> read_data[15:8] == 8'h00 && read_data[5:3] == 3'h0)
    else $error("unused comm bit set");

  latch_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    flag_q[13] && !clear_faults |=> flag_q[13])
    else $error("latched flag dropped without clear");

  timeout_recur_a: assert property (@(posedge clock) disable iff (!reset_n)
    clear_faults && !(|turn_on_timeout_event) |=> !flag_q[fault_status_pkg::L_TON])
    else $error("timeout flag survived clear");

  persist_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
    clear_faults && (|oc_fault_cond) |=> flag_q[fault_status_pkg::L_OC_FAULT])
    else $error("persisting overcurrent lost at clear");

  bad_cmd_a: assert property (@(posedge clock) disable iff (!reset_n)
    bad_command_event |=> flag_q[fault_status_pkg::L_BAD_CMD])
    else $error("bad command not latched");

  bad_cmd_read_a: assert property (@(posedge clock) disable iff (!reset_n)
    cml_read_s |=> read_data[7] == $past(flag_q[fault_status_pkg::L_BAD_CMD]))
    else $error("comm byte misses bad command flag");

  maker_summary_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> read_data[12] == $past(|maker_status_byte))
    else $error("summary maker bit wrong");

  margin_summary_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> read_data[8] == $past(flag_q[fault_status_pkg::L_MARGIN]))
    else $error("summary margin bit wrong");

  cml_summary_a: assert property (@(posedge clock) disable iff (!reset_n)
    summary_read_s |=> read_data[1] == $past(|flag_q[4:1]))
    else $error("summary comm bit wrong");

  timeout_byte_a: assert property (@(posedge clock) disable iff (!reset_n)
    cmd_valid && (cmd_code == fault_status_pkg::CODE_OUTPUT_VOLTAGE_SUMMARY_STATUS) |=>
      read_data[2] == $past(flag_q[fault_status_pkg::L_TON]))
    else $error("voltage byte timeout bit wrong");

  log_live_a: assert property (@(posedge clock) disable iff (!reset_n)
    !log_is_full |=> !log_full_flag)
    else $error("log full without full log");

  log_wrap_a: assert property (@(posedge clock) disable iff (!reset_n)
    log_is_full && log_wraparound_enable && log_overwrite |=> !log_full_flag)
    else $error("log full kept over overwrite");

  quiet_alert_a: assert property (@(posedge clock) disable iff (!reset_n)
    !alert_pending && !(|(flag_set & fault_status_pkg::ALERT_MASK)) |=> !alert_pending)
    else $error("alert raised by silent flag");

  alert_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    !alert_enable |=> alert_n)
    else $error("alert while disabled");

  alert_raise_a: assert property (@(posedge clock) disable iff (!reset_n)
    alert_raise_s |=> !alert_n)
    else $error("alert not raised");

  clear_all_a: assert property (@(posedge clock) disable iff (!reset_n)
    clear_faults |=> flag_q == $past(flag_set))
    else $error("clear did not re-evaluate flags");

  clear_silent_a: assert property (@(posedge clock) disable iff (!reset_n)
    clear_faults |=> !read_valid)
    else $error("clear answered on read port");

endmodule : pmbus_fault_status_bank

// file: verif/pmbus_host_model.sv
// behavioural host that issues status commands and collects the answers
module pmbus_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  input wire logic [15:0] read_data,
  input wire logic read_valid,
  input wire logic read_known
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////////////
  // idle command port from time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end

  // one command beat; the code is inverted afterwards so a stale code never looks valid
  task automatic send(input logic [7:0] code);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask : send

  // read command, then a bounded wait for the answer pulse; the pulse already
  // stands at the negedge that ends the command beat, so look before waiting
  task automatic read_reg(input logic [7:0] code, output logic [15:0] data, output logic known, output logic ok);
    ok = 1'b0;
    data = 16'h0000;
    known = 1'b0;
    send(code);
    for (int i = 0; i < 3 && !ok; i++)
    begin
      if (read_valid === 1'b1)
      begin
        ok = 1'b1;
        data = read_data;
        known = read_known;
      end
      else
      begin
        @(negedge clock);
      end
    end
  endtask : read_reg

  // clear-faults carries no answer on the read port
  task automatic clear_faults();
    send(fault_status_pkg::CODE_CLEAR_FAULTS);
  endtask : clear_faults
endmodule : pmbus_host_model

// file: verif/testbench.sv
// self-checking bench for the fault status bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, cmd_valid, read_valid, read_known, alert_n, alert_enable;
  logic bad_command_event, bad_data_event, secondary_array_corrupt_event, main_array_corrupt_event;
  logic log_is_full, log_overwrite, log_wraparound_enable;
  logic [7:0] cmd_code, maker_status_byte;
  logic [15:0] read_data, ov_fault_cond, ov_warn_cond, uv_warn_cond, uv_fault_cond, oc_fault_cond, oc_warn_cond;
  logic [11:0] turn_on_timeout_event, margin_fault_event, power_lost, sequenced_off;
  logic [4:0] overheat_fault_flag_cond, overheat_warning_flag_cond;
  int error_cnt, samples_checked;
  // per source: register read, expected byte, expected summary, may it alert
  localparam logic [7:0] SRC_CODE [14] = '{8'h7A, 8'h7A, 8'h7A, 8'h7A, 8'h7A, 8'h7B, 8'h7B, 8'h7D, 8'h7D,
    8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h79};
  localparam logic [15:0] SRC_BYTE [14] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0004, 16'h0080,
    16'h0020, 16'h0080, 16'h0040, 16'h0080, 16'h0040, 16'h0004, 16'h0002, 16'h0100};
  localparam logic [15:0] SRC_SUM [14] = '{16'h8020, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h4010,
    16'h4000, 16'h0004, 16'h0004, 16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h0100};
  localparam logic [13:0] SRC_ALERT = 14'h27FF;

  ////////////////////////////////////////////////////////////////////////////////
  pmbus_fault_status_bank pmbus_fault_status_bank_inst (.clock(clock), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .read_data(read_data), .read_valid(read_valid),
    .read_known(read_known), .ov_fault_cond(ov_fault_cond), .ov_warn_cond(ov_warn_cond),
    .uv_warn_cond(uv_warn_cond), .uv_fault_cond(uv_fault_cond), .turn_on_timeout_event(turn_on_timeout_event),
    .oc_fault_cond(oc_fault_cond), .oc_warn_cond(oc_warn_cond), .overheat_fault_flag_cond(overheat_fault_flag_cond),
    .overheat_warning_flag_cond(overheat_warning_flag_cond), .margin_fault_event(margin_fault_event), .power_lost(power_lost),
    .sequenced_off(sequenced_off), .maker_status_byte(maker_status_byte), .bad_command_event(bad_command_event),
    .bad_data_event(bad_data_event), .secondary_array_corrupt_event(secondary_array_corrupt_event),
    .main_array_corrupt_event(main_array_corrupt_event), .log_is_full(log_is_full), .log_overwrite(log_overwrite),
    .log_wraparound_enable(log_wraparound_enable), .alert_enable(alert_enable), .alert_n(alert_n));
  pmbus_host_model pmbus_host_model_inst (.clock(clock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .read_data(read_data), .read_valid(read_valid), .read_known(read_known));

  ////////////////////////////////////////////////////////////////////////////////
  // free-running 50 ns clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_alert(input logic exp);
    check({15'h0000, alert_n}, {15'h0000, exp});
  endtask : check_alert

  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // full-width reads, so unassigned bits are compared as well
  task automatic expect_reg(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] data;
    logic known, ok;
    pmbus_host_model_inst.read_reg(code, data, known, ok);
    if (ok !== 1'b1)
    begin
      error_cnt++;
      end_sim();
    end
    else
    begin
      check(data, exp);
      check({15'h0000, known}, 16'h0001);
    end
  endtask : expect_reg

  // boundary channels where a vector is involved
  task automatic drive_src(input int k, input logic v);
    case (k)
      0: ov_fault_cond[15] = v;
      1: ov_warn_cond[15] = v;
      2: uv_warn_cond[0] = v;
      3: uv_fault_cond[0] = v;
      4: turn_on_timeout_event[11] = v;
      5: oc_fault_cond[15] = v;
      6: oc_warn_cond[0] = v;
      7: overheat_fault_flag_cond[4] = v;
      8: overheat_warning_flag_cond[0] = v;
      9: bad_command_event = v;
      10: bad_data_event = v;
      11: secondary_array_corrupt_event = v;
      12: main_array_corrupt_event = v;
      default: margin_fault_event[0] = v;
    endcase
  endtask : drive_src

  ////////////////////////////////////////////////////////////////////////////////
  task automatic after_reset();
    logic [15:0] data;
    logic known, ok;
    for (int i = 0; i < 5; i++)
      expect_reg(i == 4 ? 8'h79 : SRC_CODE[i == 0 ? 0 : i * 2 + 3], 16'h0000);
    pmbus_host_model_inst.read_reg(8'h80, data, known, ok);
    check(data, 16'h0000);
    check({15'h0000, known}, 16'h0000);
    check_alert(1'b1);
  endtask : after_reset

  // one-cycle stimulus per source: must latch, summarise, alert or not, and clear for good
  task automatic latch_each_source();
    for (int k = 0; k < 14; k++)
    begin
      @(negedge clock);
      drive_src(k, 1'b1);
      @(negedge clock);
      drive_src(k, 1'b0);
      expect_reg(SRC_CODE[k], SRC_BYTE[k]);
      expect_reg(8'h79, SRC_SUM[k]);
      check_alert(~SRC_ALERT[k]);
      pmbus_host_model_inst.clear_faults();
      expect_reg(SRC_CODE[k], 16'h0000);
      check_alert(1'b1);
    end
  endtask : latch_each_source

  task automatic persisting_conditions();
    @(negedge clock);
    ov_fault_cond[0] = 1'b1;
    oc_fault_cond[0] = 1'b1;
    overheat_warning_flag_cond[0] = 1'b1;
    expect_reg(8'h79, 16'hC034);
    pmbus_host_model_inst.clear_faults();
    expect_reg(8'h7A, 16'h0080);
    expect_reg(8'h7B, 16'h0080);
    expect_reg(8'h7D, 16'h0040);
    // flags that set again across the clear request the alert anew
    check_alert(1'b0);
    ov_fault_cond[0] = 1'b0;
    oc_fault_cond[0] = 1'b0;
    overheat_warning_flag_cond[0] = 1'b0;
    pmbus_host_model_inst.clear_faults();
    expect_reg(8'h79, 16'h0000);
    check_alert(1'b1);
  endtask : persisting_conditions

  task automatic live_summary_bits();
    @(negedge clock);
    maker_status_byte = 8'h80;
    power_lost[11] = 1'b1;
    sequenced_off[0] = 1'b1;
    expect_reg(8'h79, 16'h1840);
    check_alert(1'b1);
    power_lost[11] = 1'b0;
    expect_reg(8'h79, 16'h1040);
    maker_status_byte = 8'h00;
    sequenced_off[0] = 1'b0;
    expect_reg(8'h79, 16'h0000);
  endtask : live_summary_bits

  task automatic log_full_flag();
    @(negedge clock);
    log_is_full = 1'b1;
    expect_reg(8'h7E, 16'h0001);
    pmbus_host_model_inst.clear_faults();
    expect_reg(8'h7E, 16'h0001);
    check_alert(1'b1);
    log_wraparound_enable = 1'b1;
    log_overwrite = 1'b1;
    // the read lands on the edge after overwrite and full log both drop, and shows the flag cleared on the overwrite edge
    fork
      expect_reg(8'h7E, 16'h0000);
      begin
        @(negedge clock);
        log_overwrite = 1'b0;
        log_is_full = 1'b0;
      end
    join
  endtask : log_full_flag

  task automatic alert_gating();
    @(negedge clock);
    alert_enable = 1'b0;
    drive_src(0, 1'b1);
    @(negedge clock);
    drive_src(0, 1'b0);
    repeat (3) @(negedge clock);
    check_alert(1'b1);
    alert_enable = 1'b1;
    repeat (2) @(negedge clock);
    check_alert(1'b0);
    pmbus_host_model_inst.clear_faults();
    repeat (2) @(negedge clock);
    check_alert(1'b1);
  endtask : alert_gating

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard: a run this long means a stuck handshake
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_sim();
  end

  // reset, then the scenarios in turn
  initial
  begin
    {ov_fault_cond, ov_warn_cond, uv_warn_cond, uv_fault_cond, oc_fault_cond, oc_warn_cond} = '0;
    {turn_on_timeout_event, margin_fault_event, power_lost, sequenced_off, overheat_fault_flag_cond, overheat_warning_flag_cond} = '0;
    {bad_command_event, bad_data_event, secondary_array_corrupt_event, main_array_corrupt_event} = 4'h0;
    {log_is_full, log_overwrite, log_wraparound_enable, maker_status_byte} = 11'h000;
    alert_enable = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    after_reset();
    latch_each_source();
    persisting_conditions();
    live_summary_bits();
    log_full_flag();
    alert_gating();
    end_sim();
  end
endmodule : testbench
